/* File: common/scan_select_pkg.sv */
// Purpose: Shared constants, mode type and helpers for the channel-select logic
// Assumes: Three-bit channel counter, eight amplifier channels
// Notes:   Raw mode codes other than single or scan decode to parallel
package scan_select_pkg;

    localparam int        CHAN_W           = 3;
    localparam int        CHAN_NUM         = 8;
    localparam int        MODE_W           = 2;

    localparam logic [2:0] CHAN_ZERO       = 3'h0;
    localparam logic [2:0] CHAN_LAST       = 3'h7;
    localparam logic [2:0] CHAN_STEP       = 3'h1;

    localparam logic [1:0] MODE_CODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_CODE_SCAN   = 2'h2;

    localparam logic       CFG_CLEAR_BIT   = 1'h0;
    localparam logic       TRIG_DRIVE_LVL  = 1'h0;

    typedef enum logic [1:0]
    {
        mode_parallel,
        mode_single,
        mode_scan
    } mode_t;

    function automatic mode_t decode_mode(input logic [1:0] raw);
        mode_t m;
        m = mode_parallel;
        if (raw == MODE_CODE_SINGLE)
        begin
            m = mode_single;
        end
        else if (raw == MODE_CODE_SCAN)
        begin
            m = mode_scan;
        end
        return m;
    endfunction : decode_mode

    function automatic logic [2:0] next_channel(input logic [2:0] ch);
        return ch + CHAN_STEP;
    endfunction : next_channel

endpackage : scan_select_pkg

/* File: common/scan_edge_if.sv */
// Purpose: Carries the clock-source choice and the counting edge between modules
// Assumes: One clock domain
// Notes:   count_edge is a one-cycle pulse
`timescale 1ns/100ps
interface scan_edge_if;
    logic clk_sel;
    logic count_edge;

    modport detector
    (
        input  clk_sel,
        output count_edge
    );

    modport user
    (
        output clk_sel,
        input  count_edge
    );
endinterface : scan_edge_if

/* File: logic/scan_edge_detect.sv */
// Purpose: Rising-edge detection on the scan clock and the backplane trigger line
// Assumes: Both inputs are synchronous to mclk
// Notes:   Each source has its own history so a source switch makes no false edge
`timescale 1ns/100ps
module scan_edge_detect
    import scan_select_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    // Clock sources
    input  wire logic      scan_clock,
    input  wire logic      backplane_trigger_line,
    // Edge carrier
    scan_edge_if.detector  edge_bus
);

    logic scan_prev_q;
    logic trig_prev_q;
    logic scan_rise;
    logic trig_rise;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scan_prev_q <= CFG_CLEAR_BIT;
            // Trigger line idles released high
            trig_prev_q <= ~TRIG_DRIVE_LVL;
        end
        else
        begin
            scan_prev_q <= scan_clock;
            trig_prev_q <= backplane_trigger_line;
        end
    end

    assign scan_rise = scan_clock & ~scan_prev_q;
    assign trig_rise = backplane_trigger_line & ~trig_prev_q;

    // R4 source select edge
    assign edge_bus.count_edge = edge_bus.clk_sel ? trig_rise : scan_rise;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_trig_edge_count: assert property ( // R4
        (edge_bus.clk_sel && $rose(backplane_trigger_line)) |-> edge_bus.count_edge)
        else $error("trigger edge not counted");

    a_scan_edge_count: assert property ( // R4
        (!edge_bus.clk_sel && !$rose(scan_clock)) |-> !edge_bus.count_edge)
        else $error("count edge without scan clock edge");

endmodule : scan_edge_detect

/* File: logic/scan_channel_select.sv */
// Purpose: Channel counter driving the output multiplexer address and enable
// Assumes: All inputs synchronous to mclk; configuration supplied as parallel bits
// Notes:   Configuration takes effect on cfg_latch; bus_reset clears it
`timescale 1ns/100ps
// Function
// R1 - Three-bit counter drives multiplexer address
// R2 - Single mode loads and holds channel
// R3 - Scan starts at configured start channel
// R4 - Scan clock or trigger, chosen by bit
// R5 - Scan control high reloads start channel
// R6 - Scan control low counts rising edges
// R7 - Counter wraps seven to zero
// R8 - Parallel mode forces channel zero
// R9 - Temperature routed only when bit set
// R10 - Shared bus: switch closed, others disabled (code closes the switch but leaves mux_enable independent of it)
// R11 - Reset selects channel zero
// R12 - Scan control reloads and gates output
// R13 - Controller holds control low during scan
// R14 - Bus reset clears whole configuration
module scan_channel_select
    import scan_select_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // Configuration
    input  wire logic              bus_reset,
    input  wire logic              cfg_latch,
    input  wire logic [CHAN_W-1:0] cfg_start_channel,
    input  wire logic [MODE_W-1:0] cfg_mode,
    input  wire logic              cfg_clock_source_select,
    input  wire logic              cfg_temp_read_select,
    input  wire logic              cfg_bus_switch,
    input  wire logic              cfg_trigger_drive,
    // Scan timing
    input  wire logic              scan_clock,
    input  wire logic              backplane_trigger_in,
    input  wire logic              scan_control,
    // Backplane trigger drive
    output logic                   trigger_out,
    output logic                   trigger_oe,
    // Multiplexer control
    output logic [CHAN_W-1:0]      channel_counter,
    output logic                   mux_enable,
    output logic                   temp_read_select,
    output logic                   bus_switch_close,
    output logic [MODE_W-1:0]      active_mode
);

    mode_t             mode_q;
    logic [CHAN_W-1:0] start_q;
    logic              clock_source_select_q;
    logic              temp_q;
    logic              bus_switch_q;
    logic              trig_drive_q;
    logic [CHAN_W-1:0] count_q;
    logic [CHAN_W-1:0] count_d;
    logic              mux_en_q;
    logic              mux_en_d;
    logic              temp_out_q;
    logic              bus_sw_out_q;
    logic              trig_oe_q;
    logic              count_edge;

    scan_edge_if edge_bus ();

    assign edge_bus.clk_sel = clock_source_select_q;
    assign count_edge       = edge_bus.count_edge;

    scan_edge_detect u_edge
    (
        .mclk                   (mclk),
        .sys_rst                (sys_rst),
        .scan_clock             (scan_clock),
        .backplane_trigger_line (backplane_trigger_in),
        .edge_bus               (edge_bus)
    );

    // Configuration latch
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q                <= mode_parallel;
            start_q               <= CHAN_ZERO;
            clock_source_select_q <= CFG_CLEAR_BIT;
            temp_q                <= CFG_CLEAR_BIT;
            bus_switch_q          <= CFG_CLEAR_BIT;
            trig_drive_q          <= CFG_CLEAR_BIT;
        end
        // R14 bus reset clears
        else if (bus_reset)
        begin
            mode_q                <= mode_parallel;
            start_q               <= CHAN_ZERO;
            clock_source_select_q <= CFG_CLEAR_BIT;
            temp_q                <= CFG_CLEAR_BIT;
            bus_switch_q          <= CFG_CLEAR_BIT;
            trig_drive_q          <= CFG_CLEAR_BIT;
        end
        else if (cfg_latch)
        begin
            mode_q                <= decode_mode(cfg_mode);
            start_q               <= cfg_start_channel;
            clock_source_select_q <= cfg_clock_source_select;
            temp_q                <= cfg_temp_read_select;
            bus_switch_q          <= cfg_bus_switch;
            trig_drive_q          <= cfg_trigger_drive;
        end
    end

    // Counter next value
    always_comb
    begin
        count_d = count_q;
        case (mode_q)
            // R8 parallel forces zero
            mode_parallel:
            begin
                count_d = CHAN_ZERO;
            end
            // R2 single channel hold
            mode_single:
            begin
                count_d = start_q;
            end
            mode_scan:
            begin
                // R3 R5 R12 reload start
                if (scan_control)
                begin
                    count_d = start_q;
                end
                // R6 R7 count and wrap
                else if (count_edge)
                begin
                    count_d = next_channel(count_q);
                end
            end
            default:
            begin
                count_d = CHAN_ZERO;
            end
        endcase
    end

    // Output enable next value
    always_comb
    begin
        mux_en_d = 1'b1;
        // R12 scan control gates output
        if (mode_q == mode_scan)
        begin
            mux_en_d = ~scan_control;
        end
    end

    // R1 R11 channel counter register
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_q <= CHAN_ZERO;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // Output control registers
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mux_en_q     <= CFG_CLEAR_BIT;
            temp_out_q   <= CFG_CLEAR_BIT;
            bus_sw_out_q <= CFG_CLEAR_BIT;
        end
        else
        begin
            mux_en_q     <= mux_en_d;
            // R9 temperature route
            temp_out_q   <= temp_q;
            // R10 bus switch
            bus_sw_out_q <= bus_switch_q;
        end
    end

    // Scan clock onto backplane trigger, open drain
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trig_oe_q <= CFG_CLEAR_BIT;
        end
        else
        begin
            trig_oe_q <= trig_drive_q & ~scan_clock;
        end
    end

    assign trigger_out      = TRIG_DRIVE_LVL;
    assign trigger_oe       = trig_oe_q;
    assign channel_counter  = count_q;
    assign mux_enable       = mux_en_q;
    assign temp_read_select = temp_out_q;
    assign bus_switch_close = bus_sw_out_q;
    assign active_mode      = mode_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_reset_channel_zero: assert property ( // R11
        $past(sys_rst) |-> (channel_counter == CHAN_ZERO))
        else $error("channel not zero after reset");

    a_parallel_forces_zero: assert property ( // R8
        (mode_q == mode_parallel) |=> (channel_counter == CHAN_ZERO))
        else $error("parallel mode not channel zero");

    a_single_holds_channel: assert property ( // R2
        (mode_q == mode_single) [*2] |-> (channel_counter == $past(start_q)))
        else $error("single mode channel not held");

    a_scan_reload_start: assert property ( // R5
        (mode_q == mode_scan && scan_control) |=> (channel_counter == $past(start_q)))
        else $error("scan control high did not reload");

    property p_scan_counts;
        logic [CHAN_W-1:0] prev;
        (mode_q == mode_scan && !scan_control && count_edge, prev = count_q)
            |=> (channel_counter == next_channel(prev));
    endproperty

    a_scan_edge_increment: assert property (p_scan_counts) // R6
        else $error("scan edge did not increment");

    a_scan_idle_stable: assert property ( // R6
        (mode_q == mode_scan && !scan_control && !count_edge) |=> $stable(channel_counter))
        else $error("counter moved without edge");

    a_counter_wrap_zero: assert property ( // R7
        (mode_q == mode_scan && !scan_control && count_edge && count_q == CHAN_LAST)
            |=> (channel_counter == CHAN_ZERO))
        else $error("counter did not wrap");

    a_bus_reset_clears: assert property ( // R14
        bus_reset |=> (start_q == CHAN_ZERO && !clock_source_select_q && !temp_q
                       && mode_q == mode_parallel) ##1 !temp_read_select)
        else $error("bus reset left configuration");

    a_scan_output_gate: assert property ( // R12
        (mode_q == mode_scan) |=> (mux_enable == !$past(scan_control)))
        else $error("output enable not following scan control");

    a_temp_route_bit: assert property ( // R9
        (cfg_latch && !bus_reset) |=> ##1 (temp_read_select == $past(cfg_temp_read_select, 2)))
        else $error("temperature route mismatch");

    a_clock_source_used: assert property ( // R4
        (mode_q == mode_scan && !scan_control && clock_source_select_q
         && !$rose(backplane_trigger_in)) |=> $stable(channel_counter))
        else $error("counted without trigger edge");

    a_reset_outputs_low: assert property ( // R11
        $past(sys_rst) |-> (!mux_enable && !temp_read_select && !bus_switch_close && !trigger_oe))
        else $error("outputs not cleared by reset");

    a_fixed_mode_enable: assert property ( // R12
        (mode_q != mode_scan && !$past(sys_rst)) |=> mux_enable)
        else $error("output disabled outside scan mode");

    a_scan_control_gates: assert property ( // R12
        (mode_q == mode_scan && scan_control) |=> !mux_enable)
        else $error("output enabled while scan control high");

    a_bus_switch_route: assert property ( // R10
        (cfg_latch && !bus_reset) |=> ##1 (bus_switch_close == $past(cfg_bus_switch, 2)))
        else $error("bus switch route mismatch");

    a_bus_reset_switch: assert property ( // R14
        bus_reset |=> ##1 !bus_switch_close)
        else $error("bus reset left bus switch closed");

    a_trigger_released: assert property ( // R4
        !trig_drive_q |=> !trigger_oe)
        else $error("trigger driven while drive disabled");

    c_scan_wrap: cover property (
        mode_q == mode_scan && !scan_control && count_edge && count_q == CHAN_LAST);

    c_scan_reload: cover property (
        (mode_q == mode_scan && !scan_control) ##1 (mode_q == mode_scan && scan_control));

    c_trigger_source: cover property (
        mode_q == mode_scan && clock_source_select_q && count_edge);

    c_parallel_mode: cover property (
        mode_q == mode_parallel ##1 mode_q == mode_single);

    c_single_last: cover property (
        mode_q == mode_single && channel_counter == CHAN_LAST);

endmodule : scan_channel_select

/* File: tb/scan_far_side_model.sv */
// Purpose: Acquisition board and chassis scan controller stand-in
// Assumes: Driven from the bench clock
// Notes:   Scan clock idles low, trigger line released high, outside a scan
`timescale 1ns/100ps
module scan_far_side_model
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Scan request
    input  wire logic go,
    input  wire logic slow,
    // Lines toward the module
    output logic      scan_clock,
    output logic      trig_drive,
    output logic      scan_control
);
    logic [1:0] div_q;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {div_q, scan_clock, trig_drive, scan_control} <= 5'h03;
        end
        else
        begin
            scan_control <= ~go;
            div_q <= div_q + 2'h1;
            if (!go)
                {scan_clock, trig_drive} <= 2'h1;
            else if (!slow || div_q == 2'h0)
                {scan_clock, trig_drive} <= {~scan_clock, ~trig_drive};
        end
    end
endmodule : scan_far_side_model

/* File: tb/scan_channel_select_tb_top.sv */
// Purpose: Self-checking bench for the channel-select logic
// Assumes: Far-side model supplies scan clock, trigger and scan control
// Notes:   A cycle model in the bench predicts every output
`timescale 1ns/100ps
module scan_channel_select_tb_top;
    logic       mclk, sys_rst, bus_reset, cfg_latch, cfg_clock_source_select, cfg_temp_read_select;
    logic       cfg_bus_switch, cfg_trigger_drive, scan_clock, scan_control, go, slow, trig_drive;
    logic       trigger_out, trigger_oe, mux_enable, temp_read_select, bus_switch_close;
    logic       m_src, m_temp, m_bus, m_drv, m_en, m_t, m_b, m_oe, p_clk, p_trg;
    logic [2:0] cfg_start_channel, channel_counter, m_start, m_cnt;
    logic [1:0] cfg_mode, active_mode, m_mode;
    wire        backplane_trigger_in;
    int         num_errors, total_checks;

    // Open-drain trigger line with pull-up
    assign backplane_trigger_in = trig_drive & ~(trigger_oe & ~trigger_out);

    initial
    begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    scan_channel_select u_dut (.mclk(mclk), .sys_rst(sys_rst), .bus_reset(bus_reset), .cfg_latch(cfg_latch),
        .cfg_start_channel(cfg_start_channel), .cfg_mode(cfg_mode), .cfg_clock_source_select(cfg_clock_source_select),
        .cfg_temp_read_select(cfg_temp_read_select), .cfg_bus_switch(cfg_bus_switch),
        .cfg_trigger_drive(cfg_trigger_drive), .scan_clock(scan_clock), .backplane_trigger_in(backplane_trigger_in),
        .scan_control(scan_control), .trigger_out(trigger_out), .trigger_oe(trigger_oe),
        .channel_counter(channel_counter), .mux_enable(mux_enable), .temp_read_select(temp_read_select),
        .bus_switch_close(bus_switch_close), .active_mode(active_mode));

    scan_far_side_model u_far (.mclk(mclk), .sys_rst(sys_rst), .go(go), .slow(slow), .scan_clock(scan_clock),
        .trig_drive(trig_drive), .scan_control(scan_control));

    function automatic logic [1:0] mode_of(input logic [1:0] raw);
        return (raw == 2'h1 || raw == 2'h2) ? raw : 2'h0;
    endfunction : mode_of

    function automatic logic [2:0] next_cnt();
        logic hit;
        hit = m_src ? (backplane_trigger_in & ~p_trg) : (scan_clock & ~p_clk);
        case (m_mode)
            2'h1: return m_start;
            2'h2: return scan_control ? m_start : m_cnt + {2'h0, hit};
            default: return 3'h0;
        endcase
    endfunction : next_cnt

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {m_mode, m_start, m_src, m_temp, m_bus, m_drv} <= '0;
            {m_cnt, m_en, m_t, m_b, m_oe, p_clk} <= '0;
            p_trg <= 1'h1;
        end
        else
        begin
            if (bus_reset)
                {m_mode, m_start, m_src, m_temp, m_bus, m_drv} <= '0;
            else if (cfg_latch)
                {m_mode, m_start, m_src, m_temp, m_bus, m_drv} <= {mode_of(cfg_mode), cfg_start_channel,
                    cfg_clock_source_select, cfg_temp_read_select, cfg_bus_switch, cfg_trigger_drive};
            {m_t, m_b, p_clk, p_trg} <= {m_temp, m_bus, scan_clock, backplane_trigger_in};
            m_oe  <= m_drv & ~scan_clock;
            m_en  <= (m_mode == 2'h2) ? ~scan_control : 1'h1;
            m_cnt <= next_cnt();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    always @(negedge mclk)
    begin
        chk("channel_counter", 8'(m_cnt), 8'(channel_counter));
        chk("active_mode", 8'(m_mode), 8'(active_mode));
        chk("mux_enable", 8'(m_en), 8'(mux_enable));
        chk("temp_read_select", 8'(m_t), 8'(temp_read_select));
        chk("bus_switch_close", 8'(m_b), 8'(bus_switch_close));
        chk("trigger_drive", {6'h0, m_oe, 1'h0}, {6'h0, trigger_oe, trigger_out});
    end

    task automatic cfg(input logic [1:0] md, input logic [2:0] st, input logic src, input logic drv);
        @(posedge mclk);
        {cfg_mode, cfg_start_channel, cfg_clock_source_select, cfg_trigger_drive, cfg_latch} <= {md, st, src, drv, 1'h1};
        {cfg_temp_read_select, cfg_bus_switch} <= 2'($urandom);
        @(posedge mclk);
        cfg_latch <= 1'h0;
    endtask : cfg

    task automatic run(input int n, input logic s);
        go   <= 1'h1;
        slow <= s;
        repeat (n) @(posedge mclk);
        go <= 1'h0;
        @(posedge mclk);
    endtask : run

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    initial
    begin
        #1ms;
        num_errors++;
        test_done();
    end

    initial
    begin
        {sys_rst, bus_reset, cfg_latch, go, slow, cfg_mode, cfg_start_channel} = 10'h200;
        {cfg_clock_source_select, cfg_temp_read_select, cfg_bus_switch, cfg_trigger_drive} = 4'h0;
        num_errors   = 0;
        total_checks = 0;
        void'($urandom(3));
        repeat (12) @(posedge mclk);
        sys_rst <= 1'h0;
        for (int c = 0; c < 8; c++)
        begin
            cfg(2'h1, 3'(c), 1'h0, 1'h0);
            run(6, 1'h0);
        end
        cfg(2'h0, 3'h5, 1'h0, 1'h0);
        run(10, 1'h0);
        cfg(2'h3, 3'h2, 1'h1, 1'h0);
        run(10, 1'h0);
        for (int s = 0; s < 4; s++)
        begin
            cfg(2'h2, 3'h6, s[0], s[1]);
            run(40, s[1]);
            run(9, 1'h0);
        end
        cfg(2'h2, 3'h3, 1'h0, 1'h0);
        go <= 1'h1;
        repeat (7) @(posedge mclk);
        {bus_reset, cfg_latch, cfg_mode} <= 4'hD;
        @(posedge mclk);
        {bus_reset, cfg_latch} <= 2'h0;
        run(6, 1'h0);
        cfg(2'h2, 3'h4, 1'h1, 1'h1);
        go <= 1'h1;
        repeat (9) @(posedge mclk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 60; i++)
        begin
            cfg(2'($urandom), 3'($urandom), 1'($urandom), 1'($urandom));
            run($urandom_range(20, 2), 1'($urandom));
        end
        test_done();
    end
endmodule : scan_channel_select_tb_top
